// ==== design/sgt_regs.vh ====
// register offsets, field positions, reset values and timing counts of the timer
// assumes inclusion by bare name from design files under design/
`ifndef SGT_REGS_VH
`define SGT_REGS_VH
`define SGT_BASE_A 32'h4000_0000
`define SGT_BASE_B 32'h4000_0400
`define SGT_BASE_C 32'h4000_0800
`define SGT_BLOCK_MASK 32'hFFFF_FC00
`define SGT_OFF_LOAD 10'h000
`define SGT_OFF_COUNT 10'h004
`define SGT_OFF_SETUP 10'h008
`define SGT_OFF_CLEAR 10'h00C
`define SGT_OFF_FLAGS 10'h01C
`define SGT_SETUP_RESET 16'h000A
`define SGT_SETUP_MASK 16'h00FF
`define SGT_B_PRE_LO 0
`define SGT_B_PRE_HI 1
`define SGT_B_UP 2
`define SGT_B_PERIODIC 3
`define SGT_B_ENABLE 4
`define SGT_B_CLK_LO 5
`define SGT_B_CLK_HI 6
`define SGT_B_RELOAD_CLR 7
`define SGT_B_TIMEOUT 0
`define SGT_B_BUSY_SETUP 6
`define SGT_B_BUSY_CLEAR 7
`define SGT_FULL_SCALE 16'hFFFF
`define SGT_ZERO_SCALE 16'h0000
`define SGT_PER_UP_END 16'hFFFE
`define SGT_PER_DOWN_END 16'h0001
`define SGT_SYNC_EDGES 2
`define SGT_PRE_W 15
`endif

// ==== design/sgt_timer_core.v ====
// one timer instance: register file, source select, prescaler and counter
// assumes a single system clock; source clocks arrive as pins and are synchronised here
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "sgt_regs.vh"
module sgt_timer_core (
  input wire clock,
  input wire rstn,
  input wire clk_en,
  input wire sel,
  input wire [9:0] offset,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire core_clock_pin,
  input wire lfosc_pin,
  input wire root_clock_pin,
  output wire [15:0] rdata_c,
  output wire irq
);
  reg [15:0] reload_q;
  reg [15:0] setup_q;
  reg [15:0] count_q;
  reg [15:0] view1_q;
  reg [15:0] view2_q;
  reg flag_q;
  reg [2:0] src_s1_q;
  reg [2:0] src_s2_q;
  reg [2:0] src_s3_q;
  reg [`SGT_PRE_W-1:0] pre_q;
  reg [1:0] setup_busy_q;
  reg [1:0] clear_busy_q;
  reg load_pend_q;
  reg [15:0] load_hold_q;
  reg [15:0] rdata_q;
  reg run_q;
  wire at_end;
  wire up;
  wire periodic;
  wire enable;
  wire [1:0] src_sel;
  wire src_rise;
  reg pre_done;
  reg [15:0] start_val;
  wire tick;
  wire timeout;
  wire wr_load;
  wire wr_setup;
  wire clear_hit;

  assign up = setup_q[`SGT_B_UP];
  assign periodic = setup_q[`SGT_B_PERIODIC];
  assign enable = setup_q[`SGT_B_ENABLE];
  assign src_sel = setup_q[`SGT_B_CLK_HI:`SGT_B_CLK_LO];
  assign wr_load = sel & wr & (offset == `SGT_OFF_LOAD);
  assign wr_setup = sel & wr & (offset == `SGT_OFF_SETUP);
  assign clear_hit = sel & wr & (offset == `SGT_OFF_CLEAR) & wdata[0];

  ////////////////////////////////////////////////////////////////////////////
  // source clocks: two flops each, then a third for rising-edge detection
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      src_s1_q <= 3'b000;
      src_s2_q <= 3'b000;
      src_s3_q <= 3'b000;
    end else if (clk_en) begin
      src_s1_q <= {root_clock_pin, lfosc_pin, core_clock_pin};
      src_s2_q <= src_s1_q;
      src_s3_q <= src_s2_q;
    end
  end

  // source 0 is the peripheral clock itself, so every cycle is an edge
  assign src_rise = (src_sel == 2'd0) ? 1'b1 :
                    (src_s2_q[src_sel - 2'd1] & ~src_s3_q[src_sel - 2'd1]);

  // prescale code 3 is 32768; a divide by 256 has no code of its own
  always @* begin
    case (setup_q[`SGT_B_PRE_HI:`SGT_B_PRE_LO])
      2'd0: pre_done = 1'b1;
      2'd1: pre_done = (pre_q[1:0] == 2'h3);
      2'd2: pre_done = (pre_q[3:0] == 4'hF);
      2'd3: pre_done = (pre_q == 15'h7FFF);
      default: pre_done = 1'b1;
    endcase
  end

  // no tick in the start cycle, so a zero count left by disable cannot time out
  assign tick = enable & run_q & src_rise & pre_done;
  // periodic mode reloads on the tick taken at the end value, keeping the down period at load ticks
  assign at_end = periodic ? (count_q == (up ? `SGT_PER_UP_END : `SGT_PER_DOWN_END)) :
                             (count_q == (up ? `SGT_FULL_SCALE : `SGT_ZERO_SCALE));
  assign timeout = tick & at_end;

  always @* begin
    if (periodic)
      start_val = load_pend_q ? load_hold_q : reload_q;
    else
      start_val = up ? `SGT_ZERO_SCALE : `SGT_FULL_SCALE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and prescaler
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_q <= 16'h0000;
      pre_q <= 15'h0000;
      run_q <= 1'b0;
    end else if (clk_en) begin
      if (!enable) begin
        count_q <= 16'h0000;
        pre_q <= 15'h0000;
        run_q <= 1'b0;
      end else begin
        if (src_rise)
          pre_q <= pre_done ? 15'h0000 : pre_q + 15'h0001;
        if (!run_q) begin
          count_q <= start_val;
          run_q <= 1'b1;
        end else if (clear_hit && setup_q[`SGT_B_RELOAD_CLR])
          count_q <= start_val;
        else if (timeout)
          count_q <= start_val;
        else if (tick)
          count_q <= up ? count_q + 16'h0001 : count_q - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; a load write on a periodic timeout tick is held until the next cycle
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reload_q <= 16'h0000;
      setup_q <= `SGT_SETUP_RESET;
      load_pend_q <= 1'b0;
      load_hold_q <= 16'h0000;
      setup_busy_q <= 2'b00;
      clear_busy_q <= 2'b00;
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_load && periodic && timeout) begin
        load_pend_q <= 1'b1;
        load_hold_q <= wdata;
      end else if (wr_load) begin
        reload_q <= wdata;
        load_pend_q <= 1'b0;
      end else if (load_pend_q) begin
        reload_q <= load_hold_q;
        load_pend_q <= 1'b0;
      end
      if (wr_setup) begin
        setup_q <= wdata & `SGT_SETUP_MASK;
        setup_busy_q <= 2'b11;
      end else if (src_rise)
        setup_busy_q <= {1'b0, setup_busy_q[1]};
      // busy lasts two timer source edges, matching the domain crossing
      if (clear_hit || (wr_setup && (wdata[`SGT_B_ENABLE] != enable)))
        clear_busy_q <= 2'b11;
      else if (src_rise)
        clear_busy_q <= {1'b0, clear_busy_q[1]};
      if (timeout)
        flag_q <= 1'b1;
      else if (clear_hit)
        flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readable count lags by two cycles; read data registered
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      view1_q <= 16'h0000;
      view2_q <= 16'h0000;
      rdata_q <= 16'h0000;
    end else if (clk_en) begin
      view1_q <= count_q;
      view2_q <= view1_q;
      rdata_q <= 16'h0000;
      if (sel && rd) begin
        case (offset)
          `SGT_OFF_LOAD: rdata_q <= reload_q;
          `SGT_OFF_COUNT: rdata_q <= view2_q;
          `SGT_OFF_SETUP: rdata_q <= setup_q;
          `SGT_OFF_FLAGS: rdata_q <= {8'h00, |clear_busy_q, |setup_busy_q, 5'h00, flag_q};
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign rdata_c = rdata_q;
  assign irq = flag_q;
endmodule

// ==== design/sgt_timer_top.v ====
// three identical 16-bit timers on one plain register port
// assumes a synchronous master on clock; source clocks are asynchronous pins
//
// What this block does
// - counting clock chosen from four sources
// - prescaler divides by 1, 4, 16, 32768
// - free mode spans full range then wraps
// - periodic mode counts from load, reloads on timeout
// - control bit 2 chooses up or down
// - interrupt at zero down or maximum up in free mode, at 1 or FFFE in periodic mode
// - enable one, periodic zero starts free running
// - every timeout sets status bit 0
// - writing clear bit 0 drops flag, interrupt
// - reload-on-clear bit makes clear reload counter
// - down period is load times prescale
// - status bit 6 busy while setup syncs
// - status bit 7 busy two source periods
// - three instances at three base addresses
// - disable resets the counter to zero
// - periodic load write at timeout held until after
// - readable count lags two cycles
`timescale 1ns/1ps
`include "sgt_regs.vh"
module sgt_timer_top (
  input wire clock,
  input wire rstn,
  input wire clk_en,
  input wire [31:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output wire [31:0] rdata,
  input wire core_clock_pin,
  input wire lfosc_pin,
  input wire root_clock_pin,
  output wire [2:0] irq
);
  wire [2:0] sel;
  wire [15:0] rd_a;
  wire [15:0] rd_b;
  wire [15:0] rd_c;
  wire [31:0] blk;

  assign blk = addr & `SGT_BLOCK_MASK;
  assign sel[0] = (blk == `SGT_BASE_A);
  assign sel[1] = (blk == `SGT_BASE_B);
  assign sel[2] = (blk == `SGT_BASE_C);
  // unselected and unmapped reads return zero since each core clears its read data
  assign rdata = {16'h0000, rd_a | rd_b | rd_c};

  sgt_timer_core u_a (
    .clock(clock), .rstn(rstn), .clk_en(clk_en), .sel(sel[0]), .offset(addr[9:0]),
    .wdata(wdata[15:0]), .wr(wr), .rd(rd), .core_clock_pin(core_clock_pin),
    .lfosc_pin(lfosc_pin), .root_clock_pin(root_clock_pin), .rdata_c(rd_a), .irq(irq[0])
  );
  sgt_timer_core u_b (
    .clock(clock), .rstn(rstn), .clk_en(clk_en), .sel(sel[1]), .offset(addr[9:0]),
    .wdata(wdata[15:0]), .wr(wr), .rd(rd), .core_clock_pin(core_clock_pin),
    .lfosc_pin(lfosc_pin), .root_clock_pin(root_clock_pin), .rdata_c(rd_b), .irq(irq[1])
  );
  sgt_timer_core u_c (
    .clock(clock), .rstn(rstn), .clk_en(clk_en), .sel(sel[2]), .offset(addr[9:0]),
    .wdata(wdata[15:0]), .wr(wr), .rd(rd), .core_clock_pin(core_clock_pin),
    .lfosc_pin(lfosc_pin), .root_clock_pin(root_clock_pin), .rdata_c(rd_c), .irq(irq[2])
  );
endmodule

// ==== verif/sgt_timer_asserts.sv ====
// concurrent checks on the register port and first interrupt line of the timer block
// assumes one clock, bound to the top module's ports
`timescale 1ns/1ps
module sgt_timer_asserts (
  input wire clock,
  input wire rstn,
  input wire clk_en,
  input wire [31:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire [2:0] irq
);
  localparam logic [31:0] A = 32'h4000_0000;
  logic [7:0] age_q;
  ////////////////////////////////////////////////////////////////////////////////
  // cycles since the last clear write to the first timer, saturating
  always @(posedge clock or negedge rstn) begin
    if (!rstn) age_q <= 8'hFF;
    else if (clk_en && wr && wdata[0] && addr == A + 32'hC) age_q <= 8'h00;
    else if (age_q != 8'hFF) age_q <= age_q + 8'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence rd_at(logic [9:0] o);
    rd && clk_en && addr == A + o;
  endsequence
  sequence wr_gap_rd(logic [9:0] o);
    wr && clk_en && addr == A + o ##1 !wr ##1 rd_at(o);
  endsequence
  a_read_idle_zero: assert property ($past(clk_en) && !$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_upper_half_zero: assert property (rdata[31:16] == 16'h0)
    else $error("upper read data bits set");
  a_unmapped_zero: assert property (rd_at(10'h010) |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_spare: assert property (rd_at(10'h01C) |=> rdata[5:1] == 5'h0 && rdata[15:8] == 8'h0)
    else $error("reserved status bits set");
  a_status_irq: assert property (rd_at(10'h01C) |=> rdata[0] == $past(irq[0]))
    else $error("status bit 0 disagrees with interrupt");
  a_setup_back: assert property (wr_gap_rd(10'h008) |=> rdata[15:0] == ($past(wdata[15:0], 3) & 16'h00FF))
    else $error("setup readback wrong");
  a_load_back: assert property (wr_gap_rd(10'h000) |=> rdata[15:0] == $past(wdata[15:0], 3))
    else $error("load readback wrong");
  a_irq_fall_clear: assert property ($fell(irq[0]) |-> age_q == 8'h00)
    else $error("interrupt dropped without a clear");
endmodule

// ==== verif/sgt_timer_top_tb.sv ====
// self-checking bench for the three-timer block
// assumes the design files are compiled first; source pins toggle freely
`timescale 1ns/1ps
module sgt_timer_top_tb;
  localparam logic [31:0] A = 32'h4000_0000;
  typedef struct { bit w; logic [31:0] a; logic [15:0] d; } sgt_row_t;
  logic clock = 0, rstn = 0, clk_en = 1, wr = 0, rd = 0;
  logic core_clock_pin = 0, lfosc_pin = 0, root_clock_pin = 0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, v, v2;
  wire [31:0] rdata;
  wire [2:0] irq;
  int n_fail = 0, samples_checked = 0, k;
  sgt_row_t rows [] = '{'{0, A + 32'h8, 16'h000A}, '{0, A, 16'h0}, '{0, A + 32'h4, 16'h0},
    '{0, A + 32'hC, 16'h0}, '{0, A + 32'h1C, 16'h0}, '{1, A + 32'h8, 16'h0001},
    '{0, A + 32'h8, 16'h0001}, '{1, A, 16'h0005}, '{0, A, 16'h0005},
    '{1, A + 32'h400, 16'h1234}, '{0, A + 32'h400, 16'h1234}, '{0, A + 32'h800, 16'h0},
    '{1, A + 32'h808, 16'h01E3}, '{0, A + 32'h808, 16'h00E3}, '{1, A + 32'h10, 16'hFFFF},
    '{0, A + 32'h10, 16'h0}, '{0, A + 32'hC00, 16'h0}};
  sgt_timer_top i_dut (.clock(clock), .rstn(rstn), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .core_clock_pin(core_clock_pin),
    .lfosc_pin(lfosc_pin), .root_clock_pin(root_clock_pin), .irq(irq));
  always #5 clock = ~clock;
  always #13 core_clock_pin = ~core_clock_pin;
  always #71 lfosc_pin = ~lfosc_pin;
  always #29 root_clock_pin = ~root_clock_pin;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // read data are taken just after the answer edge, where they stand settled
  task automatic get(input logic [31:0] a, output logic [31:0] r);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 r = rdata;
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) put(rows[i].a, {16'h0, rows[i].d});
      else begin
        get(rows[i].a, v);
        check(v, {16'h0, rows[i].d});
      end
    end
    // periodic, down, divide by 4, from a load of 5: timeout 20 cycles after the write
    put(A + 32'h8, 32'h19);
    repeat (19) @(posedge clock);
    #1 check({31'h0, irq[0]}, 32'h0);
    @(posedge clock);
    #1 check({31'h0, irq[0]}, 32'h1);
    get(A + 32'h1C, v);
    check(v & 32'h1, 32'h1);
    put(A + 32'h8, 32'h0);
    // the readable count lags, so let the cleared count reach it
    repeat (2) @(posedge clock);
    get(A + 32'h4, v);
    check(v, 32'h0);
    check({31'h0, irq[0]}, 32'h1);
    put(A + 32'hC, 32'h1);
    repeat (8) @(posedge clock);
    check({31'h0, irq[0]}, 32'h0);
    for (k = 0; k < 20 && (k == 0 || v[7]); k++) get(A + 32'h1C, v);
    check(v & 32'h81, 32'h0);
    // load while stopped, count down every cycle, reload by a clear; the frozen
    // stretch after it must not move the count
    put(A, 32'h400);
    put(A + 32'h8, 32'h98);
    repeat (20) @(posedge clock);
    put(A + 32'hC, 32'h1);
    clk_en <= 1'b0;
    repeat (10) @(posedge clock);
    clk_en <= 1'b1;
    repeat (8) @(posedge clock);
    get(A + 32'h4, v);
    check(v, 32'h3F9);
    // slow source: both busy bits hold until two of its edges have passed
    put(A + 32'h8, 32'h0);
    repeat (2) @(posedge clock);
    put(A + 32'h8, 32'h50);
    get(A + 32'h1C, v);
    check(v & 32'hC0, 32'hC0);
    for (k = 0; k < 100 && (v & 32'hC0) != 0; k++) get(A + 32'h1C, v);
    check(v & 32'hC0, 32'h0);
    get(A + 32'h4, v);
    get(A + 32'h4, v2);
    if (v != v2) get(A + 32'h4, v2);
    check({31'h0, v2 < 32'hFFFF && v2 > 32'hFF00}, 32'h1);
    rstn <= 1'b0;
    #1;
    check({29'h0, irq}, 32'h0);
    check(rdata, 32'h0);
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    get(A + 32'h8, v);
    check(v, 32'h000A);
    get(A, v);
    check(v, 32'h0);
    close_out();
  end
endmodule
bind sgt_timer_top sgt_timer_asserts i_chk (.clock(clock), .rstn(rstn), .clk_en(clk_en),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
